// ==== hw/tpfc_defs.vh ====
`ifndef TPFC_DEFS_VH
`define TPFC_DEFS_VH
// Register byte offsets
`define TPFC_OFF_FLCTL     12'h304
`define TPFC_OFF_SYNC      12'h308
`define TPFC_OFF_AUX_IN    12'h400
`define TPFC_OFF_AUX_OUT   12'h404
`define TPFC_OFF_IT_ACK    12'hEE4
`define TPFC_OFF_IT_IN     12'hEE8
`define TPFC_OFF_IT_DATA   12'hEEC
`define TPFC_OFF_IT_HS     12'hEF0
`define TPFC_OFF_ITCTRL    12'hF00
`define TPFC_OFF_STATUS    12'h300
// Flush/formatter control bit positions
`define TPFC_B_EMBED_OFF   0
`define TPFC_B_CONT        1
`define TPFC_B_FL_IN       2
`define TPFC_B_FL_TRIG     3
`define TPFC_B_FL_MANR     4
`define TPFC_B_FL_MANW     5
`define TPFC_B_TRIG_IN     6
`define TPFC_B_TRIG_EVT    7
`define TPFC_B_TRIG_FL     8
`define TPFC_B_STOP_FL     12
`define TPFC_B_STOP_TRIG   13
`define TPFC_FLCTL_MASK    32'h0000_31FF
// Reset values and sync reload ceiling
`define TPFC_RST_FLCTL     32'h0000_0000
`define TPFC_RST_SYNC      12'h000
`define TPFC_SYNC_MAX      12'h400
`endif

// ==== hw/tpfc_top.v ====
// Operation
// R1: Embed-off sends triggers on control pin
// R2: Flush input honoured only when enabled
// R3: Trigger event starts flush when enabled
// R4: Manual request bit clears when serviced
// R5: Manual write bit reads one when serviced
// R6: Trigger input pin raises trigger indication
// R7: Trigger event raises trigger indication
// R8: Flush completion raises trigger indication
// R9: Stop-on-flush drains partial packets
// R10: Stop-on-trigger halts formatter, resets disabled
// R11: Twelve-bit sync reload value, 0 to 1024
// R12: Aux input bits read sampled pins
// R13: Aux output bits drive pins directly
// R14: Ack register drives trigger/flush acknowledges
// R15: Input register reads trigger/flush pins
// R16: Data bits read inputs, drive outputs
// R17: Data reads valid only while valid high
// R18: Handshake register drives ready, flush-valid
// R19: Mode bit selects integration control
// R20: Controls reset zero, flush serviced once
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "tpfc_defs.vh"
module tpfc_top (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        trigger_in,
   input  wire        flush_in,
   input  wire        trigger_event,
   input  wire        trace_flush_ready,
   input  wire        trace_valid_in,
   input  wire [4:0]  trace_data_in,
   input  wire [7:0]  aux_in,
   output reg  [7:0]  aux_out,
   output reg         trigger_in_ack,
   output reg         flush_in_ack,
   output reg  [4:0]  trace_data_out,
   output reg         trace_ready,
   output reg         flush_valid,
   output reg         trace_ctl,
   output reg         trigger_embed,
   output reg         formatter_stopped,
   output reg         drain_partial,
   output reg  [11:0] sync_reload_value
);
   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   reg [1:0] s_trig, s_flin, s_evt, s_afr, s_tv;
   reg [4:0] d1_data, d2_data;
   reg [7:0] d1_aux, d2_aux;
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_trig  <= 2'h0;
         s_flin  <= 2'h0;
         s_evt   <= 2'h0;
         s_afr   <= 2'h0;
         s_tv    <= 2'h0;
         d1_data <= 5'h00;
         d2_data <= 5'h00;
         d1_aux  <= 8'h00;
         d2_aux  <= 8'h00;
      end else begin
         s_trig  <= {s_trig[0], trigger_in};
         s_flin  <= {s_flin[0], flush_in};
         s_evt   <= {s_evt[0], trigger_event};
         s_afr   <= {s_afr[0], trace_flush_ready};
         s_tv    <= {s_tv[0], trace_valid_in};
         d1_data <= trace_data_in;
         d2_data <= d1_data;
         d1_aux  <= aux_in;
         d2_aux  <= d1_aux;
      end
   end
   wire trig_s = s_trig[1];
   wire flin_s = s_flin[1];
   wire evt_s  = s_evt[1];
   wire afr_s  = s_afr[1];

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   reg [31:0] flush_ctl;
   reg        itest_mode_select;
   reg [7:0]  aux_out_reg;
   reg [1:0]  it_ack;
   reg [4:0]  it_data;
   reg [1:0]  it_hs;
   reg        flush_busy;
   reg        manw_done;
   reg        trig_q, evt_q, afr_q;

   wire trigger_embed_off     = flush_ctl[`TPFC_B_EMBED_OFF];
   wire flush_on_input_enable = flush_ctl[`TPFC_B_FL_IN];
   wire flush_on_trigger      = flush_ctl[`TPFC_B_FL_TRIG];
   wire manual_flush_request  = flush_ctl[`TPFC_B_FL_MANR];
   wire trigger_on_input      = flush_ctl[`TPFC_B_TRIG_IN];
   wire trigger_on_event      = flush_ctl[`TPFC_B_TRIG_EVT];
   wire trigger_on_flush_done = flush_ctl[`TPFC_B_TRIG_FL];
   wire stop_on_flush         = flush_ctl[`TPFC_B_STOP_FL];
   wire stop_on_trigger       = flush_ctl[`TPFC_B_STOP_TRIG];

   wire evt_rise   = evt_s & ~evt_q;
   wire trig_rise  = trig_s & ~trig_q;
   wire flush_done = flush_busy & afr_s & ~afr_q;

   // Trigger sources, each gated by its own enable
   wire trig_ind = (trigger_on_input & trig_rise)          // [R6]
                 | (trigger_on_event & evt_rise)           // [R7]
                 | (trigger_on_flush_done & flush_done);   // [R8]

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path: address and data taken in either order
   reg        aw_have, w_have;
   reg [11:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0]  w_strb;
   wire       wr_go = aw_have & w_have & ~s_axi_bvalid;
   wire [31:0] sm = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
   wire [31:0] flush_ctl_wr = ((flush_ctl & ~sm) | (w_data & sm)) & `TPFC_FLCTL_MASK;
   wire wr_flush_ctl = wr_go & (aw_addr == `TPFC_OFF_FLCTL);
   wire wr_manw = wr_flush_ctl & flush_ctl_wr[`TPFC_B_FL_MANW];

   // Flush sources; one merged request keeps a flush serviced once
   wire flush_req = (flush_on_input_enable & flin_s & ~flush_in_ack)   // [R2]
                  | (flush_on_trigger & evt_rise)                      // [R3]
                  | (wr_flush_ctl & flush_ctl_wr[`TPFC_B_FL_MANR])     // [R4]
                  | wr_manw;                                           // [R5]

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
         aw_have       <= 1'b0;
         w_have        <= 1'b0;
         aw_addr       <= 12'h000;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
         flush_ctl     <= `TPFC_RST_FLCTL;               // [R20] [R10]
         sync_reload_value <= `TPFC_RST_SYNC;
         itest_mode_select <= 1'b0;
         aux_out_reg   <= 8'h00;
         it_ack        <= 2'h0;
         it_data       <= 5'h00;
         it_hs         <= 2'h0;
         flush_busy    <= 1'b0;
         manw_done     <= 1'b0;
         formatter_stopped <= 1'b0;
         trig_q        <= 1'b0;
         evt_q         <= 1'b0;
         afr_q         <= 1'b0;
      end else begin
         trig_q <= trig_s;
         evt_q  <= evt_s;
         afr_q  <= afr_s;
         s_axi_awready <= ~aw_have & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready  <= ~w_have & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_have <= 1'b1;
            aw_addr <= {s_axi_awaddr[11:2], 2'b00};
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_have <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (s_axi_bvalid & s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (wr_go) begin
            aw_have      <= 1'b0;
            w_have       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'h0;
            case (aw_addr)
               `TPFC_OFF_FLCTL:   flush_ctl <= flush_ctl_wr;
               `TPFC_OFF_SYNC:    if (w_strb[0] & w_strb[1])
                                     sync_reload_value <= (w_data[11:0] > `TPFC_SYNC_MAX) ?
                                        `TPFC_SYNC_MAX : w_data[11:0];   // [R11]
               `TPFC_OFF_AUX_IN:  ;
               `TPFC_OFF_AUX_OUT: if (w_strb[0]) aux_out_reg <= w_data[7:0];  // [R13]
               `TPFC_OFF_IT_ACK:  if (w_strb[0]) it_ack <= w_data[1:0];       // [R14]
               `TPFC_OFF_IT_IN:   ;
               `TPFC_OFF_IT_DATA: if (w_strb[0]) it_data <= w_data[4:0];      // [R16]
               `TPFC_OFF_IT_HS:   if (w_strb[0]) it_hs <= w_data[1:0];        // [R18]
               `TPFC_OFF_ITCTRL:  if (w_strb[0]) itest_mode_select <= w_data[0]; // [R19]
               `TPFC_OFF_STATUS:  ;
               default:           s_axi_bresp <= 2'h2;
            endcase
         end
         // Flush sequencing: one busy flag, completion on flush-ready rise
         // New request wins over completion in flush_busy and the request bit; completion wins in manw_done
         if (flush_req)
            flush_busy <= 1'b1;                           // [R20]
         else if (flush_done)
            flush_busy <= 1'b0;
         if (flush_done)
            manw_done <= 1'b1;                            // [R5]
         else if (wr_manw)
            manw_done <= 1'b0;
         if (flush_done & ~(wr_flush_ctl & flush_ctl_wr[`TPFC_B_FL_MANR]))
            flush_ctl[`TPFC_B_FL_MANR] <= 1'b0;           // [R4]
         // Stop latches; clearing the enable restarts the formatter
         if (stop_on_trigger & trig_ind)
            formatter_stopped <= 1'b1;                    // [R10]
         else if (wr_flush_ctl & ~flush_ctl_wr[`TPFC_B_STOP_TRIG])
            formatter_stopped <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h0000_0000;
      case ({s_axi_araddr[11:2], 2'b00})
         `TPFC_OFF_FLCTL:   rd_mux = (flush_ctl & ~(32'h1 << `TPFC_B_FL_MANW))
                                   | ({31'h0, manw_done} << `TPFC_B_FL_MANW);
         `TPFC_OFF_SYNC:    rd_mux = {20'h00000, sync_reload_value};
         `TPFC_OFF_AUX_IN:  rd_mux = {24'h000000, d2_aux};                  // [R12]
         `TPFC_OFF_AUX_OUT: rd_mux = {24'h000000, aux_out_reg};
         `TPFC_OFF_IT_ACK:  rd_mux = {30'h0, it_ack};
         `TPFC_OFF_IT_IN:   rd_mux = {30'h0, flin_s, trig_s};               // [R15]
         // Data only meaningful while trace valid is high
         `TPFC_OFF_IT_DATA: rd_mux = {27'h0, d2_data};                      // [R16] [R17]
         `TPFC_OFF_IT_HS:   rd_mux = {30'h0, it_hs};
         `TPFC_OFF_ITCTRL:  rd_mux = {31'h0, itest_mode_select};
         `TPFC_OFF_STATUS:  rd_mux = {30'h0, formatter_stopped, flush_busy};
         default:           rd_mux = 32'h0000_0000;
      endcase
   end
   wire rd_hit = ({s_axi_araddr[11:2], 2'b00} == `TPFC_OFF_FLCTL)
              | ({s_axi_araddr[11:2], 2'b00} == `TPFC_OFF_SYNC)
              | ({s_axi_araddr[11:2], 2'b00} == `TPFC_OFF_AUX_IN)
              | ({s_axi_araddr[11:2], 2'b00} == `TPFC_OFF_AUX_OUT)
              | ({s_axi_araddr[11:2], 2'b00} == `TPFC_OFF_IT_ACK)
              | ({s_axi_araddr[11:2], 2'b00} == `TPFC_OFF_IT_IN)
              | ({s_axi_araddr[11:2], 2'b00} == `TPFC_OFF_IT_DATA)
              | ({s_axi_araddr[11:2], 2'b00} == `TPFC_OFF_IT_HS)
              | ({s_axi_araddr[11:2], 2'b00} == `TPFC_OFF_ITCTRL)
              | ({s_axi_araddr[11:2], 2'b00} == `TPFC_OFF_STATUS);

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'h0;
      end else begin
         s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin outputs: integration mode hands pins to the test registers
   always @(posedge aclk) begin
      if (!aresetn) begin
         aux_out        <= 8'h00;
         trigger_in_ack <= 1'b0;
         flush_in_ack   <= 1'b0;
         trace_data_out <= 5'h00;
         trace_ready    <= 1'b0;
         flush_valid    <= 1'b0;
         trace_ctl      <= 1'b0;
         trigger_embed  <= 1'b0;
         drain_partial  <= 1'b0;
      end else begin
         aux_out <= aux_out_reg;                                    // [R13]
         if (itest_mode_select) begin                               // [R19]
            trigger_in_ack <= it_ack[0];                            // [R14]
            flush_in_ack   <= it_ack[1];                            // [R14]
            trace_data_out <= it_data;                              // [R16]
            trace_ready    <= it_hs[0];                             // [R18]
            flush_valid    <= it_hs[1];                             // [R18]
            trace_ctl      <= 1'b0;
            trigger_embed  <= 1'b0;
            drain_partial  <= 1'b0;
         end else begin
            trigger_in_ack <= trigger_on_input & trig_s;
            // Ack held while input high so a held request flushes once
            flush_in_ack   <= flush_on_input_enable & flin_s & (flush_busy | flush_in_ack);
            trace_data_out <= 5'h00;
            // Stopped formatter swallows further trace words
            trace_ready    <= formatter_stopped;
            flush_valid    <= flush_busy;
            trace_ctl      <= trigger_embed_off & (trig_ind | formatter_stopped);  // [R1]
            trigger_embed  <= ~trigger_embed_off & trig_ind;                       // [R1]
            drain_partial  <= stop_on_flush & flush_busy;                          // [R9]
         end
      end
   end
endmodule // tpfc_top

// ==== tb/tpfc_checker.sv ====
`timescale 1ns/1ps
module tpfc_checker (
   input wire        aclk,
   input wire        aresetn,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire        trigger_in,
   input wire        trigger_event,
   input wire        trace_flush_ready,
   input wire        trace_ctl,
   input wire        trigger_embed,
   input wire        formatter_stopped,
   input wire [7:0]  aux_out,
   input wire [11:0] sync_reload_value
);
   logic [3:0] wr_age;
   logic [3:0] trig_age;
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge aclk) begin
      if (!aresetn) begin
         wr_age   <= 4'hF;
         trig_age <= 4'hF;
      end else begin
         if (s_axi_awvalid && s_axi_awready) wr_age <= 4'h0;
         else if (wr_age != 4'hF) wr_age <= wr_age + 4'h1;
         // Any trigger source restarts the age; hides the sync pipeline depth
         if (trigger_in || trigger_event || trace_flush_ready) trig_age <= 4'h0;
         else if (trig_age != 4'hF) trig_age <= trig_age + 4'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_resp_after_addr: assert property ($rose(s_axi_bvalid) |-> wr_age < 4'h6)
      else $error("write response without address");
   chk_resp_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid)
      else $error("read answer late");
   chk_embed_split: assert property (!(trigger_embed && trace_ctl))
      else $error("trigger on both paths");
   chk_sync_ceiling: assert property (sync_reload_value <= 12'h400)
      else $error("sync reload above ceiling");
   chk_sync_by_write: assert property ($changed(sync_reload_value) |-> wr_age < 4'h6)
      else $error("sync reload moved without write");
   chk_aux_by_write: assert property ($changed(aux_out) |-> wr_age < 4'h6)
      else $error("aux outputs moved without write");
   chk_reset_quiet: assert property ($rose(aresetn) |->
      !formatter_stopped && !trigger_embed && aux_out == 8'h00)
      else $error("outputs not cleared by reset");
   chk_embed_cause: assert property ($rose(trigger_embed) |-> trig_age < 4'h8)
      else $error("embedded trigger without cause");
   chk_stop_cause: assert property ($rose(formatter_stopped) |-> trig_age < 4'h8)
      else $error("formatter stopped without trigger");
   chk_embed_pulse: assert property (trigger_embed |=> !trigger_embed)
      else $error("embedded trigger longer than one cycle");
   cover property ($rose(trigger_embed));
   cover property ($rose(trace_ctl));
   cover property ($rose(formatter_stopped));
endmodule // tpfc_checker

bind tpfc_top tpfc_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .trigger_in, .trigger_event, .trace_flush_ready, .trace_ctl, .trigger_embed,
   .formatter_stopped, .aux_out, .sync_reload_value);

// ==== tb/tpfc_partner.sv ====
`timescale 1ns/1ps
module tpfc_partner (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        kick,
   input  wire [7:0]  dly,
   input  wire        data_on,
   input  wire [4:0]  data_val,
   output logic       trace_flush_ready,
   output logic       trace_valid_in,
   output logic [4:0] trace_data_in
);
   logic [8:0] cnt;
   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt               <= 9'h000;
         trace_flush_ready <= 1'b0;
         trace_valid_in    <= 1'b0;
         trace_data_in     <= 5'h00;
      end else begin
         if (cnt != 9'h000) cnt <= cnt - 9'h001;
         else if (kick) cnt <= {1'b0, dly} + 9'h004;
         // Held three cycles so the pin synchroniser cannot miss it
         trace_flush_ready <= (cnt != 9'h000) && (cnt < 9'h004);
         trace_valid_in    <= data_on;
         // Idle data toggles so a stale word never looks valid
         trace_data_in     <= data_on ? data_val : ~trace_data_in;
      end
   end
endmodule // tpfc_partner

// ==== tb/tb_trace_port_formatter_control.sv ====
`timescale 1ns/1ps
`include "tpfc_defs.vh"
`define CHK(n, e, g) begin \
   num_checks = num_checks + 1; \
   if ((g) !== (e)) begin \
      fail_count = fail_count + 1; \
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); \
   end \
end
module tb_trace_port_formatter_control;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000;
   logic [11:0] s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_bready = 1'b1;
   logic        s_axi_rready = 1'b1;
   logic        trigger_in = 1'b0;
   logic        flush_in = 1'b0;
   logic        trigger_event = 1'b0;
   logic [7:0]  aux_in = 8'h00;
   logic        kick = 1'b0;
   logic        data_on = 1'b0;
   logic [4:0]  data_val = 5'h00;
   logic [7:0]  dly = 8'h00;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   wire         trace_flush_ready, trace_valid_in, trigger_in_ack, flush_in_ack;
   wire  [4:0]  trace_data_in, trace_data_out;
   wire  [7:0]  aux_out;
   wire         trace_ready, flush_valid, trace_ctl, trigger_embed;
   wire         formatter_stopped, drain_partial;
   wire  [11:0] sync_reload_value;
   logic [31:0] rdat;
   logic [1:0]  resp;
   logic [11:0] rst_map [5] = '{`TPFC_OFF_FLCTL, `TPFC_OFF_SYNC, `TPFC_OFF_AUX_OUT,
                                 `TPFC_OFF_IT_ACK, `TPFC_OFF_IT_HS};
   integer      fail_count = 0;
   integer      num_checks = 0;
   integer      n_emb = 0;
   integer      n_ctl = 0;
   integer      e0;
   ////////////////////////////////////////////////////////////////////////////////
   tpfc_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trigger_in, .flush_in, .trigger_event,
      .trace_flush_ready, .trace_valid_in, .trace_data_in, .aux_in, .aux_out,
      .trigger_in_ack, .flush_in_ack, .trace_data_out, .trace_ready, .flush_valid,
      .trace_ctl, .trigger_embed, .formatter_stopped, .drain_partial, .sync_reload_value);
   tpfc_partner u_far (.aclk, .aresetn, .kick, .dly, .data_on, .data_val,
      .trace_flush_ready, .trace_valid_in, .trace_data_in);
   always #50 aclk = ~aclk;
   always @(posedge aclk) begin
      n_emb <= n_emb + trigger_embed;
      n_ctl <= n_ctl + trace_ctl;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      resp = s_axi_bresp;
   endtask
   task automatic rd(input logic [11:0] a);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
   endtask
   task automatic chk_rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      rd(a);
      `CHK($sformatf("reg_%h", a), e, rdat & m)
   endtask
   task automatic wchk(input logic [11:0] a, input logic [31:0] d, m, e);
      wr(a, d);
      chk_rd(a, m, e);
   endtask
   task automatic hit(input logic [2:0] s);
      {flush_in, trigger_event, trigger_in} <= s;
      tick(4);
      {flush_in, trigger_event, trigger_in} <= 3'b000;
      tick(12);
   endtask
   task automatic poke();
      kick <= 1'b1;
      tick(1);
      kick <= 1'b0;
   endtask
   task automatic trig_case(input logic [31:0] f, input logic [2:0] s, input integer ee, ec);
      integer c0;
      wr(`TPFC_OFF_FLCTL, f);
      e0 = n_emb;
      c0 = n_ctl;
      hit(s);
      `CHK("embed_pulses", ee, n_emb - e0)
      `CHK("ctl_pulses", ec, n_ctl - c0)
   endtask
   task automatic flush_case(input logic [31:0] f, input logic [2:0] s, input logic [31:0] e);
      wr(`TPFC_OFF_FLCTL, f);
      hit(s);
      chk_rd(`TPFC_OFF_STATUS, 32'h1, e);
      `CHK("flush_pins", {f[12] & e[0], e[0]}, {drain_partial, flush_valid})
      poke();
      tick(12);
   endtask
   task automatic close_out();
      if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6000) @(posedge aclk);
      fail_count = fail_count + 1;
      close_out();
   end
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 5; i++) chk_rd(rst_map[i], 32'hFFFF_FFFF, 32'h0);
      rd(12'h010);
      `CHK("unmapped_rresp", 2'b10, resp)
      `CHK("unmapped_rdata", 32'h0, rdat)
      wr(12'h010, 32'h1);
      `CHK("unmapped_bresp", 2'b10, resp)
      wchk(`TPFC_OFF_SYNC, 32'h400, 32'hFFF, 32'h400);
      wchk(`TPFC_OFF_SYNC, 32'hFFF, 32'hFFF, 32'h400);
      wchk(`TPFC_OFF_SYNC, 32'h3FF, 32'hFFF, 32'h3FF);
      `CHK("sync_port", 12'h3FF, sync_reload_value)
      aux_in <= 8'h3C;
      tick(4);
      chk_rd(`TPFC_OFF_AUX_IN, 32'hFF, 32'h3C);
      wchk(`TPFC_OFF_AUX_OUT, 32'hA5, 32'hFF, 32'hA5);
      `CHK("aux_pins", 8'hA5, aux_out)
      trig_case(32'h40, 3'b001, 1, 0);
      trig_case(32'h41, 3'b001, 0, 1);
      trig_case(32'h80, 3'b010, 1, 0);
      trig_case(32'h00, 3'b011, 0, 0);
      // Slow far side first, so the pending state is visible
      dly <= 8'd20;
      wchk(`TPFC_OFF_FLCTL, 32'h20, 32'h20, 32'h0);
      chk_rd(`TPFC_OFF_STATUS, 32'h1, 32'h1);
      poke();
      tick(40);
      chk_rd(`TPFC_OFF_FLCTL, 32'h20, 32'h20);
      chk_rd(`TPFC_OFF_STATUS, 32'h1, 32'h0);
      dly <= 8'd0;
      e0 = n_emb;
      wchk(`TPFC_OFF_FLCTL, 32'h110, 32'h10, 32'h10);
      poke();
      tick(20);
      chk_rd(`TPFC_OFF_FLCTL, 32'h10, 32'h0);
      `CHK("flush_done_trigger", 1, n_emb - e0)
      flush_case(32'h0, 3'b100, 32'h0);
      flush_case(32'h1004, 3'b100, 32'h1);
      flush_case(32'h8, 3'b010, 32'h1);
      wr(`TPFC_OFF_FLCTL, 32'h2040);
      hit(3'b001);
      `CHK("stopped", 2'b11, {formatter_stopped, trace_ready})
      chk_rd(`TPFC_OFF_STATUS, 32'h2, 32'h2);
      wr(`TPFC_OFF_FLCTL, 32'h0);
      tick(3);
      `CHK("stop_release", 1'b0, formatter_stopped)
      wr(`TPFC_OFF_ITCTRL, 32'h1);
      wr(`TPFC_OFF_IT_ACK, 32'h2);
      tick(2);
      `CHK("ack_pins", 2'b10, {flush_in_ack, trigger_in_ack})
      wr(`TPFC_OFF_IT_HS, 32'h1);
      tick(2);
      `CHK("handshake_pins", 2'b01, {flush_valid, trace_ready})
      wr(`TPFC_OFF_IT_DATA, 32'h15);
      tick(2);
      `CHK("data_pins", 5'h15, trace_data_out)
      {flush_in, trigger_in} <= 2'b01;
      tick(4);
      chk_rd(`TPFC_OFF_IT_IN, 32'h3, 32'h1);
      {flush_in, trigger_in} <= 2'b10;
      tick(4);
      chk_rd(`TPFC_OFF_IT_IN, 32'h3, 32'h2);
      flush_in <= 1'b0;
      data_on  <= 1'b1;
      data_val <= 5'h0A;
      tick(4);
      chk_rd(`TPFC_OFF_IT_DATA, 32'h1F, 32'h0A);
      close_out();
   end
endmodule // tb_trace_port_formatter_control
